// ==== lmbh_ctrl.sv ====
`timescale 1ns/1ps
// Functional notes
// - we supply a three-bit column shift select; device shifts column by it
// - we report addressed bus width; device sizes transfers dynamically below 64 bits
// - we supply a three-bit cycle timing select for the current access
// - we pull fault low to flag a fault on the current row access
// - we give four-bit page size so device knows when to start rows
// - we hold ready low to insert wait states until the cycle may end
// - we drive retry low when memory is busy; device reschedules the cycle
// - during reset the user timing pin carries the byte order strap
// - request low to own, high to return; grant rises once request inactive
// - request level at reset release: low runs master CPU, high halts it
module lmbh_ctrl import lmbh_pkg::*; #(
	parameter int RESET_CNT = RESET_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// per-cycle selects to the device
	output logic [2:0] col_shift_sel,
	output logic [1:0] bus_width_sel,
	output logic [2:0] cycle_timing_sel,
	output logic [3:0] page_size_sel,
	output logic user_timing_sel,
	// cycle replies to the device
	output logic ready,
	output logic retry_n,
	output logic fault_n,
	// device control
	output logic dev_reset_n,
	output logic host_bus_request_n,
	output logic edge_irq_level3,
	output logic host_drive_en_n,
	// device outputs, asynchronous to pclk
	input wire logic row_latch_n,
	input wire logic [7:0] col_strobe_mask,
	input wire logic [5:0] cycle_status,
	input wire logic [1:0] pending_req_code,
	input wire logic host_grant_n,
	input wire logic [31:0] mem_addr,
	input wire logic xcvr_enable_n,
	input wire logic xcvr_direction
);
	lmbh_obs_if obs ();

	logic [CTRL_W-1:0] ctrl_ff;
	logic [31:0] cfg0_ff;
	logic [31:0] cfg1_ff;
	logic [31:0] bound_ff;
	logic [31:0] rowaddr_ff;
	logic [31:0] count_ff;
	logic [5:0] row_stat_ff;
	logic [5:0] col_stat_ff;
	logic region_ff;
	logic [TMR_W-1:0] wait_ff;
	logic [TMR_W-1:0] retry_tmr_ff;
	logic [TMR_W-1:0] fault_tmr_ff;
	logic [TMR_W-1:0] unhalt_ff;
	logic [TMR_W-1:0] strap_ff;
	logic [15:0] rst_cnt_ff;
	logic retry_arm_ff;
	logic fault_arm_ff;
	lmbh_bus_t bus_ff;
	lmbh_bus_t nxt_bus;
	logic [31:0] cfg_sel;
	logic [31:0] rd_data;
	logic rd_ok;
	logic wr_en;
	logic rd_take;
	logic strap_phase;
	logic in_reset;

	lmbh_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.row_latch_n(row_latch_n),
		.col_strobe_mask(col_strobe_mask),
		.cycle_status(cycle_status),
		.pending_req_code(pending_req_code),
		.host_grant_n(host_grant_n),
		.mem_addr(mem_addr),
		.xcvr_enable_n(xcvr_enable_n),
		.xcvr_direction(xcvr_direction),
		.obs(obs)
	);

	function automatic logic [TMR_W-1:0] wait_of(input logic [31:0] cfg);
		wait_of = cfg[CFG_WAIT_LSB +: TMR_W];
	endfunction : wait_of
	function automatic logic [TMR_W-1:0] tick_down(input logic [TMR_W-1:0] t);
		tick_down = (t == '0) ? '0 : t - 1'b1;
	endfunction : tick_down

	// apb: one wait state, so pready and prdata can both come from flip-flops
	assign wr_en = psel & penable & pready & pwrite;
	assign rd_take = psel & penable & ~pready;
	assign in_reset = ~dev_reset_n;
	assign strap_phase = in_reset | (strap_ff != '0);
	assign cfg_sel = region_ff ? cfg1_ff : cfg0_ff;

	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0000_0000;
		case (paddr)
			OFS_CTRL: rd_data[CTRL_W-1:0] = ctrl_ff & ~(8'h01 << CTRL_UNHALT);
			OFS_CFG0: rd_data = cfg0_ff;
			OFS_CFG1: rd_data = cfg1_ff;
			OFS_BOUND: rd_data = bound_ff;
			OFS_STAT: begin
				rd_data[ST_GRANTED] = (bus_ff == BUS_OWN);
				rd_data[ST_STATE_LSB +: 2] = bus_ff;
				rd_data[ST_REQ_LSB +: 2] = obs.req_code;
				rd_data[ST_XEN] = obs.xcvr_en_n;
				rd_data[ST_XDIR] = obs.xcvr_dir;
				rd_data[ST_ROW_LSB +: 6] = row_stat_ff;
				rd_data[ST_COL_LSB +: 6] = col_stat_ff;
				rd_data[ST_RETRY] = retry_arm_ff;
				rd_data[ST_FAULT] = fault_arm_ff;
				rd_data[ST_INRESET] = in_reset;
			end
			OFS_ROWADDR: rd_data = rowaddr_ff;
			OFS_COUNT: rd_data = count_ff;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= rd_take;
			if (rd_take) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= ~rd_ok;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// control register; unhalt is write-one and self-clears after starting the pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_en && paddr == OFS_CTRL) begin
			ctrl_ff <= pwdata[CTRL_W-1:0];
		end else begin
			ctrl_ff[CTRL_UNHALT] <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg0_ff <= CFG_RST;
			cfg1_ff <= CFG_RST;
			bound_ff <= BOUND_RST;
		end else if (wr_en) begin
			if (paddr == OFS_CFG0) cfg0_ff <= pwdata;
			if (paddr == OFS_CFG1) cfg1_ff <= pwdata;
			if (paddr == OFS_BOUND) bound_ff <= pwdata;
		end
	end

	// device reset: held for a minimum time even if software toggles run quickly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_ff <= '0;
			dev_reset_n <= 1'b0;
		end else if (!ctrl_ff[CTRL_RUN]) begin
			rst_cnt_ff <= '0;
			dev_reset_n <= 1'b0;
		end else if (rst_cnt_ff < 16'(RESET_CNT)) begin
			rst_cnt_ff <= rst_cnt_ff + 16'h0001;
		end else begin
			dev_reset_n <= 1'b1;
		end
	end

	// straps stay put a little past the reset release so the device samples them cleanly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_ff <= '0;
		end else if (in_reset) begin
			strap_ff <= TMR_W'(STRAP_CYCLES);
		end else begin
			strap_ff <= tick_down(strap_ff);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_timing_sel <= 1'b0;
		end else if (strap_phase) begin
			user_timing_sel <= ctrl_ff[CTRL_ENDIAN];
		end else begin
			user_timing_sel <= ctrl_ff[CTRL_USER_TIMING_SEL];
		end
	end

	// bus handover
	always_comb begin
		nxt_bus = bus_ff;
		case (bus_ff)
			BUS_IDLE: if (ctrl_ff[CTRL_BUSREQ] && !strap_phase) nxt_bus = BUS_REQ;
			BUS_REQ: begin
				if (!ctrl_ff[CTRL_BUSREQ] || strap_phase) nxt_bus = BUS_REL;
				else if (!obs.grant_n) nxt_bus = BUS_OWN;
			end
			BUS_OWN: if (!ctrl_ff[CTRL_BUSREQ] || strap_phase) nxt_bus = BUS_REL;
			BUS_REL: if (obs.grant_n && host_bus_request_n) nxt_bus = BUS_IDLE;
			default: nxt_bus = BUS_IDLE;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_ff <= BUS_IDLE;
		end else begin
			bus_ff <= nxt_bus;
		end
	end

	// drive enable falls only once grant is seen; request rises a cycle after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_drive_en_n <= 1'b1;
		end else begin
			host_drive_en_n <= ~(nxt_bus == BUS_OWN);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_bus_request_n <= 1'b1;
		end else if (strap_phase && bus_ff != BUS_OWN) begin
			host_bus_request_n <= ~ctrl_ff[CTRL_START];
		end else if (bus_ff == BUS_REQ || bus_ff == BUS_OWN) begin
			host_bus_request_n <= 1'b0;
		end else if (bus_ff == BUS_REL) begin
			host_bus_request_n <= ~host_drive_en_n ? 1'b0 : 1'b1;
		end else begin
			host_bus_request_n <= 1'b1;
		end
	end

	// unhalt pulse: one clean rising edge, level held so the device cannot miss it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unhalt_ff <= '0;
			edge_irq_level3 <= 1'b0;
		end else begin
			if (ctrl_ff[CTRL_UNHALT] && !in_reset) begin
				unhalt_ff <= TMR_W'(UNHALT_CYCLES);
			end else begin
				unhalt_ff <= tick_down(unhalt_ff);
			end
			edge_irq_level3 <= (unhalt_ff != '0);
		end
	end

	// row time: capture address, cycle type and pick the decode region
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rowaddr_ff <= 32'h0000_0000;
			row_stat_ff <= 6'h00;
			region_ff <= 1'b0;
			count_ff <= 32'h0000_0000;
		end else if (obs.row_fall) begin
			rowaddr_ff <= obs.addr;
			row_stat_ff <= obs.status;
			region_ff <= (obs.addr >= bound_ff);
			count_ff <= count_ff + 32'h0000_0001;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_stat_ff <= 6'h00;
		end else if (obs.col_fall) begin
			col_stat_ff <= obs.status;
		end
	end

	// per-cycle selects follow the region of the cycle in progress
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_shift_sel <= 3'h0;
			bus_width_sel <= 2'h0;
			cycle_timing_sel <= 3'h0;
			page_size_sel <= 4'h0;
		end else begin
			col_shift_sel <= cfg_sel[CFG_SHIFT_LSB +: 3];
			bus_width_sel <= cfg_sel[CFG_WIDTH_LSB +: 2];
			cycle_timing_sel <= cfg_sel[CFG_TIMING_LSB +: 3];
			page_size_sel <= cfg_sel[CFG_PAGE_LSB +: 4];
		end
	end

	// wait states counted from the row latch edge; sync latency makes the count a minimum
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_ff <= '0;
			ready <= 1'b1;
		end else begin
			if (obs.row_fall) begin
				wait_ff <= wait_of(obs.addr >= bound_ff ? cfg1_ff : cfg0_ff);
			end else begin
				wait_ff <= tick_down(wait_ff);
			end
			ready <= ~(obs.row_fall && wait_of(obs.addr >= bound_ff ? cfg1_ff : cfg0_ff) != '0)
				& (wait_ff <= TMR_W'(1));
		end
	end

	// one-shot retry and fault; a software arm in the same cycle as use wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_arm_ff <= 1'b0;
			fault_arm_ff <= 1'b0;
		end else begin
			if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_RETRY]) retry_arm_ff <= 1'b1;
			else if (obs.row_fall) retry_arm_ff <= 1'b0;
			if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_FAULT]) fault_arm_ff <= 1'b1;
			else if (obs.row_fall) fault_arm_ff <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_tmr_ff <= '0;
			retry_n <= 1'b1;
		end else begin
			if (obs.row_fall && retry_arm_ff) retry_tmr_ff <= TMR_W'(REPLY_CYCLES);
			else retry_tmr_ff <= tick_down(retry_tmr_ff);
			retry_n <= (retry_tmr_ff == '0);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_tmr_ff <= '0;
			fault_n <= 1'b1;
		end else begin
			if (obs.row_fall && fault_arm_ff) fault_tmr_ff <= TMR_W'(REPLY_CYCLES);
			else fault_tmr_ff <= tick_down(fault_tmr_ff);
			fault_n <= (fault_tmr_ff == '0);
		end
	end
endmodule : lmbh_ctrl

// ==== lmbh_ctrl_props.sv ====
`timescale 1ns/1ps
module lmbh_ctrl_props (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// device side
	input wire logic ready,
	input wire logic retry_n,
	input wire logic fault_n,
	input wire logic dev_reset_n,
	input wire logic host_bus_request_n,
	input wire logic edge_irq_level3,
	input wire logic host_drive_en_n,
	input wire logic user_timing_sel,
	input wire logic row_latch_n,
	input wire logic host_grant_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_apb_answer_time: assert property (psel && $rose(penable) |=> pready ##1 !pready)
		else $error("pready not one cycle after access start");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside answer");
	chk_drive_needs_grant: assert property (!host_drive_en_n |-> !host_bus_request_n && !host_grant_n)
		else $error("host drives bus without grant");
	chk_grant_before_drive: assert property ($fell(host_drive_en_n) |-> !$past(host_grant_n, 2))
		else $error("host drive enabled before grant seen");
	chk_release_before_drop: assert property ($rose(host_bus_request_n) |-> host_drive_en_n && $past(host_drive_en_n))
		else $error("request dropped while still driving");
	chk_retry_pulse_len: assert property ($fell(retry_n) |=> !retry_n ##1 retry_n)
		else $error("retry pulse not two cycles");
	chk_fault_pulse_len: assert property ($fell(fault_n) |-> !fault_n [*2] ##1 fault_n)
		else $error("fault pulse not two cycles");
	chk_unhalt_pulse_len: assert property ($rose(edge_irq_level3) |-> edge_irq_level3 [*4] ##1 !edge_irq_level3)
		else $error("unhalt pulse not four cycles");
	chk_strap_stable: assert property ($rose(dev_reset_n) |-> $stable(user_timing_sel) && $stable(host_bus_request_n) ##1 $stable(user_timing_sel))
		else $error("strap moved at device reset release");
	chk_wait_has_cause: assert property ($fell(ready) |-> !row_latch_n && !$past(row_latch_n, 3))
		else $error("wait state without row latch");
	chk_wait_bounded: assert property ($fell(ready) |-> ##[1:300] ready)
		else $error("wait state never ends");
endmodule : lmbh_ctrl_props

bind lmbh_ctrl lmbh_ctrl_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .ready(ready), .retry_n(retry_n),
	.fault_n(fault_n), .dev_reset_n(dev_reset_n), .host_bus_request_n(host_bus_request_n),
	.edge_irq_level3(edge_irq_level3), .host_drive_en_n(host_drive_en_n),
	.user_timing_sel(user_timing_sel), .row_latch_n(row_latch_n), .host_grant_n(host_grant_n));

// ==== lmbh_dev_model.sv ====
`timescale 1ns/1ps
module lmbh_dev_model #(
	parameter logic [5:0] ROW_CODE = 6'h21,
	parameter logic [5:0] COL_CODE = 6'h12
) (
	// clock
	input wire logic pclk,
	// from the controller
	input wire logic dev_reset_n,
	input wire logic user_timing_sel,
	input wire logic host_bus_request_n,
	input wire logic edge_irq_level3,
	input wire logic ready,
	input wire logic retry_n,
	input wire logic fault_n,
	// cycle launch
	input wire logic go,
	input wire logic go_write,
	input wire logic [31:0] go_addr,
	// device pins
	output logic row_latch_n,
	output logic [7:0] col_strobe_mask,
	output logic [5:0] cycle_status,
	output logic [1:0] pending_req_code,
	output logic host_grant_n,
	output logic [31:0] mem_addr,
	output logic xcvr_enable_n,
	output logic xcvr_direction,
	// model state
	output logic endian_ff,
	output logic halted_ff,
	output logic retried_ff,
	output logic faulted_ff,
	output logic [7:0] done_cnt_ff
);
	logic [1:0] req_sync_ff;
	logic grant_ff, busy_ff, rl_ff, dir_ff, tog_ff, retry_seen_ff, float_w;
	logic [3:0] cnt_ff;
	logic [31:0] addr_ff;
	always @(posedge dev_reset_n) endian_ff <= user_timing_sel;
	always @(posedge dev_reset_n or posedge edge_irq_level3) begin
		if (edge_irq_level3) halted_ff <= 1'b0;
		else halted_ff <= host_bus_request_n;
	end
	always @(posedge pclk or negedge dev_reset_n) begin
		if (!dev_reset_n) begin
			req_sync_ff <= 2'b11;
			grant_ff <= 1'b1;
			busy_ff <= 1'b0;
			rl_ff <= 1'b1;
			retry_seen_ff <= 1'b0;
			{retried_ff, faulted_ff, done_cnt_ff} <= '0;
			{tog_ff, dir_ff, cnt_ff, addr_ff} <= '0;
		end else begin
			tog_ff <= !tog_ff;
			req_sync_ff <= {req_sync_ff[0], host_bus_request_n};
			if (req_sync_ff[1]) grant_ff <= 1'b1;
			else if (float_w) grant_ff <= 1'b0;
			if (!busy_ff && go && grant_ff && req_sync_ff[1]) begin
				busy_ff <= 1'b1;
				addr_ff <= go_addr;
				dir_ff <= go_write;
				cnt_ff <= 4'h0;
			end else if (busy_ff) begin
				if (cnt_ff != 4'hF) cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff == 4'h1) rl_ff <= 1'b0;
				if (!retry_n) retry_seen_ff <= 1'b1;
				if (!fault_n) faulted_ff <= 1'b1;
				if (cnt_ff >= 4'hD && ready) begin
					rl_ff <= 1'b1;
					cnt_ff <= 4'h0;
					retry_seen_ff <= 1'b0;
					if (retry_seen_ff) retried_ff <= 1'b1;
					else busy_ff <= 1'b0;
					if (!retry_seen_ff) done_cnt_ff <= done_cnt_ff + 8'h01;
				end
			end
		end
	end
	// bus released to the host: lines wander instead of holding the last value
	assign float_w = !grant_ff || (!req_sync_ff[1] && !busy_ff);
	assign host_grant_n = grant_ff | host_bus_request_n;
	assign mem_addr = float_w ? addr_ff ^ {32{tog_ff}} : addr_ff;
	assign row_latch_n = float_w | rl_ff;
	assign cycle_status = (busy_ff && cnt_ff < 4'h6) ? ROW_CODE : COL_CODE;
	assign col_strobe_mask = (busy_ff && cnt_ff >= 4'h6) ? 8'h00 : 8'hFF;
	assign xcvr_enable_n = !(busy_ff && cnt_ff >= 4'h6);
	assign xcvr_direction = dir_ff;
	assign pending_req_code = {1'b0, go && !busy_ff};
endmodule : lmbh_dev_model

// ==== lmbh_obs_if.sv ====
`timescale 1ns/1ps
interface lmbh_obs_if;
	logic row_fall;
	logic col_fall;
	logic [31:0] addr;
	logic [5:0] status;
	logic [1:0] req_code;
	logic grant_n;
	logic xcvr_en_n;
	logic xcvr_dir;
	modport src (output row_fall, col_fall, addr, status, req_code, grant_n, xcvr_en_n, xcvr_dir);
	modport dst (input row_fall, col_fall, addr, status, req_code, grant_n, xcvr_en_n, xcvr_dir);
endinterface : lmbh_obs_if

// ==== lmbh_pin_sync.sv ====
`timescale 1ns/1ps
module lmbh_pin_sync (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw device outputs
	input wire logic row_latch_n,
	input wire logic [7:0] col_strobe_mask,
	input wire logic [5:0] cycle_status,
	input wire logic [1:0] pending_req_code,
	input wire logic host_grant_n,
	input wire logic [31:0] mem_addr,
	input wire logic xcvr_enable_n,
	input wire logic xcvr_direction,
	// synchronised view
	lmbh_obs_if.src obs
);
	localparam int W = 52;
	logic [W-1:0] raw;
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	assign raw = {xcvr_direction, xcvr_enable_n, mem_addr, host_grant_n, pending_req_code,
		cycle_status, col_strobe_mask, row_latch_n};

	// strobes idle high, so reset to the inactive level to avoid a false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_ff <= {W{1'b1}};
			s2_ff <= {W{1'b1}};
			s3_ff <= {W{1'b1}};
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// the address bus is not sampled coherently; it is only used at a row latch edge,
	// by which time it has been stable for the whole synchroniser depth
	assign obs.row_fall = s3_ff[0] & ~s2_ff[0];
	assign obs.col_fall = (&s3_ff[8:1]) & ~(&s2_ff[8:1]);
	assign obs.status = s2_ff[14:9];
	assign obs.req_code = s2_ff[16:15];
	assign obs.grant_n = s2_ff[17];
	assign obs.addr = s2_ff[49:18];
	assign obs.xcvr_en_n = s2_ff[50];
	assign obs.xcvr_dir = s2_ff[51];
endmodule : lmbh_pin_sync

// ==== lmbh_pkg.sv ====
package lmbh_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG0 = 8'h04;
	localparam logic [7:0] OFS_CFG1 = 8'h08;
	localparam logic [7:0] OFS_BOUND = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_ROWADDR = 8'h14;
	localparam logic [7:0] OFS_COUNT = 8'h18;
	// control fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_ENDIAN = 1;
	localparam int CTRL_START = 2;
	localparam int CTRL_USER_TIMING_SEL = 3;
	localparam int CTRL_BUSREQ = 4;
	localparam int CTRL_UNHALT = 5;
	localparam int CTRL_RETRY = 6;
	localparam int CTRL_FAULT = 7;
	localparam int CTRL_W = 8;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// per-region cycle configuration fields (lsb positions)
	localparam int CFG_SHIFT_LSB = 0;
	localparam int CFG_WIDTH_LSB = 4;
	localparam int CFG_TIMING_LSB = 8;
	localparam int CFG_PAGE_LSB = 12;
	localparam int CFG_WAIT_LSB = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] BOUND_RST = 32'hFFFF_FFFF;
	// status fields
	localparam int ST_GRANTED = 0;
	localparam int ST_STATE_LSB = 1;
	localparam int ST_REQ_LSB = 3;
	localparam int ST_XEN = 5;
	localparam int ST_XDIR = 6;
	localparam int ST_ROW_LSB = 8;
	localparam int ST_COL_LSB = 16;
	localparam int ST_RETRY = 24;
	localparam int ST_FAULT = 25;
	localparam int ST_INRESET = 26;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_TIME_NS = 100;
	localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STRAP_HOLD_NS = 20;
	localparam int STRAP_CYCLES = (STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNHALT_NS = 40;
	localparam int UNHALT_CYCLES = (UNHALT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REPLY_NS = 20;
	localparam int REPLY_CYCLES = (REPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 8;
	// bus handover states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_REQ = 2'b01,
		BUS_OWN = 2'b11,
		BUS_REL = 2'b10
	} lmbh_bus_t;
endpackage : lmbh_pkg

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
`define WAITC(c) begin for (int k = 0; k < 400 && !(c); k++) @(posedge pclk); \
	`CHK("wait", 1'b1, (c)) end
module tb import lmbh_pkg::*;;
	typedef struct packed {logic rd; logic err; logic [31:0] mask; logic [31:0] data;} lmbh_exp_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic go = 1'b0, go_write = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, go_addr = 32'h0, rnd = 32'hC872BEBB, prdata, mem_addr;
	logic pready, pslverr, ready, retry_n, fault_n, dev_reset_n, host_bus_request_n;
	logic edge_irq_level3, host_drive_en_n, user_timing_sel, row_latch_n, host_grant_n;
	logic xcvr_enable_n, xcvr_direction, endian_ff, halted_ff, retried_ff, faulted_ff;
	logic [2:0] col_shift_sel, cycle_timing_sel;
	logic [1:0] bus_width_sel, pending_req_code;
	logic [3:0] page_size_sel;
	logic [5:0] cycle_status;
	logic [7:0] col_strobe_mask, done_cnt_ff;
	int mismatches = 0, total_checks = 0;
	lmbh_exp_t exp_q[$];
	lmbh_exp_t mon_e;
	always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
	lmbh_ctrl #(.RESET_CNT(2)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .col_shift_sel, .bus_width_sel, .cycle_timing_sel,
		.page_size_sel, .user_timing_sel, .ready, .retry_n, .fault_n, .dev_reset_n,
		.host_bus_request_n, .edge_irq_level3, .host_drive_en_n, .row_latch_n, .col_strobe_mask,
		.cycle_status, .pending_req_code, .host_grant_n, .mem_addr, .xcvr_enable_n, .xcvr_direction);
	lmbh_dev_model i_dev (.pclk, .dev_reset_n, .user_timing_sel, .host_bus_request_n,
		.edge_irq_level3, .ready, .retry_n, .fault_n, .go, .go_write, .go_addr, .row_latch_n,
		.col_strobe_mask, .cycle_status, .pending_req_code, .host_grant_n, .mem_addr,
		.xcvr_enable_n, .xcvr_direction, .endian_ff, .halted_ff, .retried_ff, .faulted_ff,
		.done_cnt_ff);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask : settle
	// one apb transfer; the expectation is queued for the monitor
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input lmbh_exp_t e);
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
		apb(1'b1, a, d, '{1'b0, err, 32'h0, 32'h0});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
		input logic err = 1'b0);
		apb(1'b0, a, 32'h0, '{1'b1, err, m, x});
	endtask : rd
	task automatic mem_cycle(input logic [31:0] a, input logic w, input logic [31:0] cfg);
		logic [7:0] d0;
		d0 = done_cnt_ff;
		go_addr <= a;
		go_write <= w;
		go <= 1'b1;
		`WAITC(row_latch_n === 1'b0)
		go <= 1'b0;
		`WAITC(done_cnt_ff !== d0)
		settle(2);
		`CHK("shift", cfg[2:0], col_shift_sel)
		`CHK("width", cfg[5:4], bus_width_sel)
		`CHK("timing", cfg[10:8], cycle_timing_sel)
		`CHK("page", cfg[15:12], page_size_sel)
		rd(OFS_ROWADDR, 32'hFFFFFFFF, a);
	endtask : mem_cycle
	always @(posedge pclk) begin
		if (pready === 1'b1 && psel && penable && exp_q.size() > 0) begin
			mon_e = exp_q.pop_front();
			`CHK("pslverr", mon_e.err, pslverr)
			if (mon_e.rd) `CHK("prdata", mon_e.data & mon_e.mask, prdata & mon_e.mask)
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CTRL, 32'hFF, {24'h0, CTRL_RST});
		rd(OFS_BOUND, 32'hFFFFFFFF, BOUND_RST);
		rd(OFS_CFG1, 32'hFFFFFFFF, CFG_RST);
		rd(8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1);
		wr(8'h20, rnd, 1'b1);
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			wr(OFS_CFG0 + 8'(4 * (i % 3)), rnd);
			rd(OFS_CFG0 + 8'(4 * (i % 3)), 32'hFFFFFFFF, rnd);
		end
		wr(OFS_COUNT, rnd);
		rd(OFS_COUNT, 32'hFFFFFFFF, 32'h0);
		// halted boot with the other byte order, then unhalt
		wr(OFS_CTRL, 32'h03);
		`WAITC(dev_reset_n === 1'b1)
		settle(4);
		`CHK("endian", 1'b1, endian_ff)
		`CHK("halted", 1'b1, halted_ff)
		wr(OFS_CTRL, 32'h23);
		settle(8);
		`CHK("unhalted", 1'b0, halted_ff)
		wr(OFS_CTRL, 32'h00);
		wr(OFS_CTRL, 32'h05);
		`WAITC(dev_reset_n === 1'b1)
		settle(4);
		`CHK("endian", 1'b0, endian_ff)
		`CHK("halted", 1'b0, halted_ff)
		wr(OFS_CFG0, 32'h000C_3221);
		wr(OFS_CFG1, 32'h0002_A517);
		wr(OFS_BOUND, 32'h8000_0000);
		mem_cycle(32'h0000_1238, 1'b0, 32'h000C_3221);
		mem_cycle(32'h8000_0000, 1'b1, 32'h0002_A517);
		mem_cycle(32'h7FFF_FFFC, 1'b0, 32'h000C_3221);
		rd(OFS_COUNT, 32'hFFFFFFFF, 32'd3);
		rd(OFS_STAT, 32'h003F_3F60, {10'h0, 6'h12, 2'h0, 6'h21, 8'h20});
		wr(OFS_CTRL, 32'h0D);
		settle(2);
		`CHK("user_timing_sel", 1'b1, user_timing_sel)
		wr(OFS_CTRL, 32'h45);
		mem_cycle(32'hFFFF_FFF0, 1'b1, 32'h0002_A517);
		`CHK("retried", 1'b1, retried_ff)
		`CHK("user_timing_sel off", 1'b0, user_timing_sel)
		rd(OFS_COUNT, 32'hFFFFFFFF, 32'd5);
		wr(OFS_CTRL, 32'h85);
		mem_cycle(32'h0000_0040, 1'b0, 32'h000C_3221);
		`CHK("faulted", 1'b1, faulted_ff)
		// take the bus as host, then hand it back
		wr(OFS_CTRL, 32'h15);
		`WAITC(host_drive_en_n === 1'b0)
		`CHK("grant", 1'b0, host_grant_n)
		rd(OFS_STAT, 32'h7, 32'h7);
		wr(OFS_CTRL, 32'h05);
		`WAITC(host_bus_request_n === 1'b1)
		`CHK("grant back", 1'b1, host_grant_n)
		settle(6);
		rd(OFS_STAT, 32'h1F, 32'h0);
		summarize();
	end
endmodule : tb
